/* hw/mct_pkg.sv */
package mct_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int AW = 4;
  localparam int DW = 8;
  localparam logic [3:0] ADR_MODE = 4'h0;
  localparam logic [3:0] ADR_CTRL = 4'h1;
  localparam logic [3:0] ADR_CLKSEL = 4'h2;
  localparam logic [3:0] ADR_CMP_A = 4'h3;
  localparam logic [3:0] ADR_CMP_B = 4'h4;
  localparam logic [3:0] ADR_MASK_A = 4'h5;
  localparam logic [3:0] ADR_MASK_B = 4'h6;
  localparam logic [3:0] ADR_STATUS = 4'h7;
  localparam logic [3:0] ADR_CAPTURE = 4'h8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] RST_MODE = 4'hF;
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [3:0] RST_CLKSEL = 4'hF;
  localparam logic [7:0] RST_CMP = 8'hFF;
  localparam logic [3:0] RST_MASK = 4'h0;

  // ****************************************
  // Mode field codes
  // ****************************************
  localparam logic [3:0] M_COUNT = 4'hF;
  localparam logic [3:0] M_EXT_TRIG = 4'hE;
  localparam logic [3:0] M_INT_TRIG = 4'hD;
  localparam logic [3:0] M_COUNT_PEER = 4'hC;
  localparam logic [3:0] M_TRIG_PEER = 4'hB;
  localparam logic [3:0] M_BURST_PEER = 4'hA;
  localparam logic [3:0] M_BURST_SER = 4'h9;
  localparam logic [3:0] M_FSK = 4'h8;
  localparam logic [3:0] M_PWM = 4'h7;
  localparam logic [3:0] M_MANCH = 4'h6;
  localparam logic [3:0] M_BIPHASE = 4'h5;
  localparam logic [3:0] M_CAPTURE = 4'h4;

  // ****************************************
  // Field codes
  // ****************************************
  localparam logic [1:0] SRC_SYS = 2'h3;
  localparam logic [1:0] SRC_PEER = 2'h2;
  localparam logic [1:0] SRC_OTHER = 2'h1;
  localparam logic [1:0] SRC_EDGE = 2'h0;
  localparam logic [1:0] EDGE_POS = 2'h2;
  localparam logic [1:0] EDGE_NEG = 2'h1;
  localparam logic [1:0] EDGE_ANY = 2'h0;
  localparam logic [7:0] CNT_MAX = 8'hFF;

  // Control word, one bit per function
  typedef struct packed {
    logic edge_irq_mask;
    logic output_preset_bit;
    logic toggle_on_start_bit;
    logic run_bit;
  } mct_ctrl_t;

  // Per-compare action mask
  typedef struct packed {
    logic single_act;
    logic toggle_en;
    logic irq_en;
    logic reset_en;
  } mct_mask_t;

  // Sticky event flags
  typedef struct packed {
    logic edge_seen_flag;
    logic match_b_flag;
    logic match_a_flag;
  } mct_stat_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_COUNT, ST_WAIT_EDGE} mct_state_t;

endpackage

/* hw/mct_timer.sv */
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - Eight-bit up-counter with two compare registers and one capture register.
// - Timer input is synchronised to the system clock, idle when clock stops.
// - Counter value readable through the capture register, except in trigger, PWM and capture modes.
// - Single-action compare fires only once per start or trigger restart.
// - Compares alternate A, B, A, B after each start.
// - With single action on one register, later compares use only the other.
// - Match resets counter, raises interrupt or toggles output per mask bits.
// - Control register starts, stops, presets output, masks edge interrupt.
// - Edge interrupt only when edge mask set and run bit clear.
// - All events share one interrupt; status register shows which occurred.
// - Compare value x gives match interval of x plus one counter clocks.
// - External trigger: first edge starts, later edges capture, reset, restart.
// - Internal trigger: peer toggle captures count, resets, restarts single actions.
// - Two modes repeat counter and external trigger modes, routing peer output.
// - Burst one: own carrier gated by peer output flip-flop.
// - Burst two: own carrier gated by serial output bit.
// - FSK: serial bit low selects compare A, high selects compare B.
// - PWM: serial bit picks compare register, peer toggle restarts counter.
// - Manchester: A match shifts input level out, next edge resets counter.
// - Manchester: compare B acts as timeout through the interrupt.
// - Biphase: toggle flip-flop samples mid-frame edge, A match shifts it.
// - External capture: input edge copies count without resetting it.
// - Four-bit mode field, twelve modes, codes 0000 to 0011 not allowed.
// - Run clear stops and resets; toggle on start; preset only while stopped.
// - Edge and match flags clear when status register is read.
// - Source field picks counter clock; edge field picks active input edge.
module mct_timer (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [mct_pkg::AW-1:0] REG_ADDR,
  input wire logic [mct_pkg::DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [mct_pkg::DW-1:0] REG_RDATA,
  // Timer input and companion signals
  input wire logic TIMER_INPUT,
  input wire logic PEER_TOGGLE,
  input wire logic PEER_OUTPUT,
  input wire logic PEER_CLK_TICK,
  input wire logic OTHER_CLK_TICK,
  input wire logic BURST_GATE,
  input wire logic SERIAL_OUT,
  // Outputs
  output logic TIMER_OUTPUT,
  output logic OWN_TOGGLE,
  output logic TIMER_IRQ,
  output logic SHIFT_CLK,
  output logic SHIFT_DATA
);
  import mct_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [3:0] mode, next_mode;
  mct_ctrl_t ctrl, next_ctrl;
  logic [3:0] clksel, next_clksel;
  logic [7:0] cmp_a, next_cmp_a;
  logic [7:0] cmp_b, next_cmp_b;
  mct_mask_t mask_a, next_mask_a;
  mct_mask_t mask_b, next_mask_b;
  mct_stat_t stat, next_stat;
  logic [7:0] capture, next_capture;
  logic [7:0] cnt, next_cnt;
  mct_state_t st, next_st;
  logic sel, next_sel;
  logic done_a, next_done_a;
  logic done_b, next_done_b;
  logic tog, next_tog;
  logic mid, next_mid;
  logic [2:0] sync, next_sync;
  logic peer_q, next_peer_q;
  logic out_q, next_out_q;
  logic irq_q, next_irq_q;
  logic shclk_q, next_shclk_q;
  logic shdat_q, next_shdat_q;
  logic [7:0] rdata, next_rdata;

  // ****************************************
  // Decode
  // ****************************************
  logic edge_evt, tick, peer_evt, mode_ok, ext_trig, int_trig, demod, ser_sel;
  logic eff_sel, use_a, use_b, hit_a, hit_b, rst_hit, restart, cap_evt;
  logic wr_ctrl, start, rd_stat;

  // Edge decoder on the second and third stages only
  always_comb
  begin
    case (clksel[3:2])
      EDGE_POS: edge_evt = sync[1] & ~sync[2];
      EDGE_NEG: edge_evt = ~sync[1] & sync[2];
      EDGE_ANY: edge_evt = sync[1] ^ sync[2];
      default: edge_evt = 1'b0;
    endcase
  end

  // Counter clock enable from the selected source
  always_comb
  begin
    case (clksel[1:0])
      SRC_SYS: tick = 1'b1;
      SRC_PEER: tick = PEER_CLK_TICK;
      SRC_OTHER: tick = OTHER_CLK_TICK;
      default: tick = edge_evt;
    endcase
  end

  // Mode classes; low codes are refused and hold the counter idle
  assign mode_ok = mode[3:2] != 2'b00;
  assign ext_trig = (mode == M_EXT_TRIG) || (mode == M_TRIG_PEER);
  assign int_trig = (mode == M_INT_TRIG) || (mode == M_PWM);
  assign demod = (mode == M_MANCH) || (mode == M_BIPHASE);
  assign ser_sel = (mode == M_FSK) || (mode == M_PWM);
  assign peer_evt = PEER_TOGGLE != peer_q;
  assign wr_ctrl = REG_WR && (REG_ADDR == ADR_CTRL);
  assign start = wr_ctrl && REG_WDATA[0] && !ctrl.run_bit;
  assign rd_stat = REG_RD && (REG_ADDR == ADR_STATUS);

  // A spent single-action register hands over to the other one
  always_comb
  begin
    eff_sel = sel;
    if (!sel && done_a)
    begin
      eff_sel = 1'b1;
    end
    else if (sel && done_b)
    begin
      eff_sel = 1'b0;
    end
  end

  // Demodulators watch both registers; FSK and PWM follow the serial bit
  always_comb
  begin
    if (demod)
    begin
      use_a = 1'b1;
      use_b = 1'b1; // B runs as timeout
    end
    else if (ser_sel)
    begin
      use_a = !SERIAL_OUT;
      use_b = SERIAL_OUT;
    end
    else
    begin
      use_a = !eff_sel;
      use_b = eff_sel;
    end
  end

  // Match when count equals x, so x+1 clocks between resets
  assign hit_a = (st == ST_COUNT) && tick && use_a && !done_a && (cnt == cmp_a);
  assign hit_b = (st == ST_COUNT) && tick && use_b && !done_b && (cnt == cmp_b);
  assign rst_hit = (hit_a && mask_a.reset_en) || (hit_b && mask_b.reset_en);

  // Trigger restarts and capture events
  assign restart = (ext_trig && st == ST_COUNT && edge_evt)
    || (int_trig && st == ST_COUNT && peer_evt)
    || (demod && st == ST_WAIT_EDGE && edge_evt);
  assign cap_evt = (ext_trig && st == ST_COUNT && edge_evt)
    || (int_trig && st == ST_COUNT && peer_evt)
    || ((mode == M_CAPTURE) && st == ST_COUNT && edge_evt);

  // ****************************************
  // Registers written by software
  // ****************************************
  // Write decode
  always_comb
  begin
    next_mode = mode;
    next_ctrl = ctrl;
    next_clksel = clksel;
    next_cmp_a = cmp_a;
    next_cmp_b = cmp_b;
    next_mask_a = mask_a;
    next_mask_b = mask_b;
    if (REG_WR)
    begin
      if (REG_ADDR == ADR_MODE)
      begin
        next_mode = REG_WDATA[3:0];
      end
      else if (REG_ADDR == ADR_CTRL)
      begin
        next_ctrl = mct_ctrl_t'(REG_WDATA[3:0]);
      end
      else if (REG_ADDR == ADR_CLKSEL)
      begin
        next_clksel = REG_WDATA[3:0];
      end
      else if (REG_ADDR == ADR_CMP_A)
      begin
        next_cmp_a = REG_WDATA;
      end
      else if (REG_ADDR == ADR_CMP_B)
      begin
        next_cmp_b = REG_WDATA;
      end
      else if (REG_ADDR == ADR_MASK_A)
      begin
        next_mask_a = mct_mask_t'(REG_WDATA[3:0]);
      end
      else if (REG_ADDR == ADR_MASK_B)
      begin
        next_mask_b = mct_mask_t'(REG_WDATA[3:0]);
      end
    end
  end

  // ****************************************
  // Counter core
  // ****************************************
  // Sequencer, counter, compare selection and capture
  always_comb
  begin
    next_sync = {sync[1:0], TIMER_INPUT};
    next_peer_q = PEER_TOGGLE;
    next_st = st;
    next_cnt = cnt;
    next_sel = sel;
    next_done_a = done_a;
    next_done_b = done_b;
    next_mid = mid;
    next_capture = capture;
    next_shclk_q = 1'b0;
    next_shdat_q = shdat_q;
    if (!ctrl.run_bit || !mode_ok)
    begin
      // Stop clears everything that belongs to a run
      next_st = ST_IDLE;
      next_cnt = 8'h00;
      next_sel = 1'b0;
      next_done_a = 1'b0;
      next_done_b = 1'b0;
      next_mid = 1'b0;
    end
    else
    begin
      case (st)
        ST_IDLE: next_st = ext_trig ? ST_ARMED : ST_COUNT;
        ST_ARMED:
        begin
          if (edge_evt)
          begin
            next_st = ST_COUNT; // First edge only starts
          end
        end
        ST_COUNT:
        begin
          if (restart)
          begin
            next_cnt = 8'h00;
            next_sel = 1'b0;
            next_done_a = 1'b0; // Restart single actions
            next_done_b = 1'b0;
            next_mid = 1'b0;
          end
          else
          begin
            if (tick)
            begin
              next_cnt = rst_hit ? 8'h00 : cnt + 8'h01;
            end
            if (hit_a || hit_b)
            begin
              next_sel = !eff_sel;
            end
            if (hit_a && mask_a.single_act)
            begin
              next_done_a = 1'b1;
            end
            if (hit_b && mask_b.single_act)
            begin
              next_done_b = 1'b1;
            end
            if ((mode == M_BIPHASE) && edge_evt)
            begin
              next_mid = !mid; // Mid-frame edge flips the bit
            end
            if (demod && hit_a)
            begin
              // Sample point: push decoded bit, then resync on edge
              next_shclk_q = 1'b1;
              next_shdat_q = (mode == M_MANCH) ? sync[1] : mid;
              next_st = ST_WAIT_EDGE;
            end
          end
        end
        default:
        begin
          if (edge_evt)
          begin
            next_st = ST_COUNT;
            next_cnt = 8'h00; // Edge resynchronises the bit timer
            next_mid = 1'b0;
            next_done_a = 1'b0;
            next_done_b = 1'b0;
          end
        end
      endcase
    end
    // Capture modes load on their event, other modes track the count
    if (cap_evt)
    begin
      next_capture = cnt;
    end
    else if (!ext_trig && !int_trig && (mode != M_CAPTURE))
    begin
      next_capture = cnt;
    end
  end

  // ****************************************
  // Output stage, flags and read port
  // ****************************************
  // Toggle flip-flop, output routing, status and interrupt
  always_comb
  begin
    next_tog = tog;
    if (wr_ctrl && !ctrl.run_bit)
    begin
      // Preset only while stopped; start may flip it at once
      next_tog = REG_WDATA[2] ^ (start & REG_WDATA[1]);
    end
    else
    begin
      next_tog = tog ^ (hit_a && mask_a.toggle_en) ^ (hit_b && mask_b.toggle_en);
    end
    case (mode)
      M_COUNT_PEER, M_TRIG_PEER, M_MANCH, M_BIPHASE: next_out_q = PEER_OUTPUT;
      M_BURST_PEER: next_out_q = tog & BURST_GATE;
      M_BURST_SER: next_out_q = tog & SERIAL_OUT;
      default: next_out_q = tog;
    endcase
    // Read clears flags, but a new event in the same cycle wins
    next_stat = rd_stat ? 3'b000 : stat;
    next_stat.match_a_flag = next_stat.match_a_flag | hit_a;
    next_stat.match_b_flag = next_stat.match_b_flag | hit_b;
    next_stat.edge_seen_flag = next_stat.edge_seen_flag | edge_evt;
    // One shared interrupt pulse
    next_irq_q = (hit_a && mask_a.irq_en) || (hit_b && mask_b.irq_en)
      || (edge_evt && ctrl.edge_irq_mask && !ctrl.run_bit);
    next_rdata = 8'h00;
    if (REG_RD)
    begin
      if (REG_ADDR == ADR_MODE)
      begin
        next_rdata = {4'h0, mode};
      end
      else if (REG_ADDR == ADR_CTRL)
      begin
        next_rdata = {4'h0, ctrl};
      end
      else if (REG_ADDR == ADR_CLKSEL)
      begin
        next_rdata = {4'h0, clksel};
      end
      else if (REG_ADDR == ADR_CMP_A)
      begin
        next_rdata = cmp_a;
      end
      else if (REG_ADDR == ADR_CMP_B)
      begin
        next_rdata = cmp_b;
      end
      else if (REG_ADDR == ADR_MASK_A)
      begin
        next_rdata = {4'h0, mask_a};
      end
      else if (REG_ADDR == ADR_MASK_B)
      begin
        next_rdata = {4'h0, mask_b};
      end
      else if (REG_ADDR == ADR_STATUS)
      begin
        next_rdata = {5'h00, stat};
      end
      else if (REG_ADDR == ADR_CAPTURE)
      begin
        next_rdata = capture;
      end
    end
  end

  // State registers
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mode <= RST_MODE;
      ctrl <= mct_ctrl_t'(RST_CTRL);
      clksel <= RST_CLKSEL;
      cmp_a <= RST_CMP;
      cmp_b <= RST_CMP;
      mask_a <= mct_mask_t'(RST_MASK);
      mask_b <= mct_mask_t'(RST_MASK);
      stat <= 3'b000;
      capture <= 8'h00;
      cnt <= 8'h00;
      st <= ST_IDLE;
      sel <= 1'b0;
      done_a <= 1'b0;
      done_b <= 1'b0;
      tog <= 1'b0;
      mid <= 1'b0;
      sync <= 3'b000;
      peer_q <= 1'b0;
      out_q <= 1'b0;
      irq_q <= 1'b0;
      shclk_q <= 1'b0;
      shdat_q <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      mode <= next_mode;
      ctrl <= next_ctrl;
      clksel <= next_clksel;
      cmp_a <= next_cmp_a;
      cmp_b <= next_cmp_b;
      mask_a <= next_mask_a;
      mask_b <= next_mask_b;
      stat <= next_stat;
      capture <= next_capture;
      cnt <= next_cnt;
      st <= next_st;
      sel <= next_sel;
      done_a <= next_done_a;
      done_b <= next_done_b;
      tog <= next_tog;
      mid <= next_mid;
      sync <= next_sync;
      peer_q <= next_peer_q;
      out_q <= next_out_q;
      irq_q <= next_irq_q;
      shclk_q <= next_shclk_q;
      shdat_q <= next_shdat_q;
      rdata <= next_rdata;
    end
  end

  // Port drive
  assign REG_RDATA = rdata;
  assign TIMER_OUTPUT = out_q;
  assign OWN_TOGGLE = tog;
  assign TIMER_IRQ = irq_q;
  assign SHIFT_CLK = shclk_q;
  assign SHIFT_DATA = shdat_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  chk_counter_wrap: assert property (
    (st == ST_COUNT && tick && cnt == CNT_MAX && !rst_hit && !restart && ctrl.run_bit
      && !wr_ctrl) |=> cnt == 8'h00)
    else $error("counter did not wrap to zero");
  chk_stop_reset: assert property (
    !ctrl.run_bit |=> cnt == 8'h00 && st == ST_IDLE)
    else $error("stopped counter not cleared");
  chk_match_reset: assert property (
    (rst_hit && !restart && ctrl.run_bit && !wr_ctrl) |=> cnt == 8'h00)
    else $error("match with reset mask did not clear counter");
  chk_single_once: assert property (
    (hit_a && mask_a.single_act && !restart) |=> !hit_a until (restart || !ctrl.run_bit))
    else $error("single action fired twice");
  chk_edge_irq: assert property (
    (edge_evt && ctrl.edge_irq_mask && !ctrl.run_bit) |=> TIMER_IRQ)
    else $error("edge interrupt missing");
  chk_fsk_select: assert property (
    (mode == M_FSK && hit_a) |-> !SERIAL_OUT)
    else $error("fsk used register A with serial bit high");
  chk_status_clear: assert property (
    (rd_stat && !hit_a && !hit_b && !edge_evt) |=> stat == 3'b000)
    else $error("status not cleared by read");
  chk_input_sync: assert property (
    ##2 sync[1] == $past(TIMER_INPUT, 2))
    else $error("input synchroniser latency wrong");
  chk_capture_hold: assert property (
    (mode == M_CAPTURE && cap_evt && ctrl.run_bit) |=> capture == $past(cnt)
      && (cnt != 8'h00 || $past(cnt) == CNT_MAX || $past(rst_hit) || !$past(tick)))
    else $error("external capture wrong");

  cov_ext_restart: cover property (ext_trig && restart);
  cov_single_b: cover property (done_a && hit_b);
  cov_manch_shift: cover property (mode == M_MANCH && SHIFT_CLK);
  cov_fsk_b: cover property (mode == M_FSK && hit_b);

endmodule

/* tb/mct_peer_model.sv */
`timescale 1ns/1ps
// ****************************************
// Companion timer and serial unit
// ****************************************
module mct_peer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Companion outputs
  output logic peer_toggle,
  output logic peer_output,
  output logic peer_tick,
  output logic other_tick,
  output logic serial_out
);
  logic [3:0] div;

  // Clock enables run free, like the real prescalers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div <= 4'h0;
    else
      div <= div + 4'h1;
  end
  assign peer_tick = (div[1:0] == 2'h3);
  assign other_tick = (div == 4'hF);

  // Levels start low
  initial
  begin
    peer_toggle = 1'b0;
    peer_output = 1'b0;
    serial_out = 1'b0;
  end

  // Levels moved just after an edge, as the companions would
  task automatic set_lines(input logic tog, input logic outp, input logic ser);
    @(posedge clk);
    peer_toggle <= tog;
    peer_output <= outp;
    serial_out <= ser;
  endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import mct_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tin = 1'b0;
  logic [DW-1:0] rdata;
  logic ptog, pout, ptick, otick, ser, tout, own_tog, irq, sclk, sdata;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;

  // ****************************************
  // Clock, parts and watchdog
  // ****************************************
  always #4 clk = ~clk;

  mct_timer i_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .TIMER_INPUT(tin),
    .PEER_TOGGLE(ptog), .PEER_OUTPUT(pout), .PEER_CLK_TICK(ptick),
    .OTHER_CLK_TICK(otick), .BURST_GATE(pout), .SERIAL_OUT(ser),
    .TIMER_OUTPUT(tout), .OWN_TOGGLE(own_tog), .TIMER_IRQ(irq),
    .SHIFT_CLK(sclk), .SHIFT_DATA(sdata)
  );

  mct_peer_model i_peer (
    .clk(clk), .rst_n(rst_n), .peer_toggle(ptog), .peer_output(pout),
    .peer_tick(ptick), .other_tick(otick), .serial_out(ser)
  );

  // A hang ends the run as a failure
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      test_done();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data only stands in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic setup(input logic [3:0] m, input logic [7:0] cs, input logic [7:0] ca,
                       input logic [7:0] cb, input logic [7:0] ma, input logic [7:0] mb);
    wr_reg(ADR_MODE, {4'h0, m});
    wr_reg(ADR_CLKSEL, cs);
    wr_reg(ADR_CMP_A, ca);
    wr_reg(ADR_CMP_B, cb);
    wr_reg(ADR_MASK_A, ma);
    wr_reg(ADR_MASK_B, mb);
  endtask

  // Edges up to and including the next interrupt pulse
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (irq !== 1'b1 && n < lim);
  endtask

  task automatic wait_tog(input int lim, output int n);
    logic t;
    t = own_tog;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (own_tog === t && n < lim);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] v;
    rd_reg(ADR_MODE, v);
    chk("mode", v, {4'h0, RST_MODE});
    rd_reg(ADR_CTRL, v);
    chk("ctrl", v, {4'h0, RST_CTRL});
    rd_reg(ADR_CLKSEL, v);
    chk("clksel", v, {4'h0, RST_CLKSEL});
    rd_reg(ADR_CMP_A, v);
    chk("cmp a", v, RST_CMP);
    rd_reg(ADR_STATUS, v);
    chk("status", v, 8'h00);
    wr_reg(4'hF, 8'h5A);
    rd_reg(4'hF, v);
    chk("unmapped", v, 8'h00);
    wr_reg(ADR_CMP_B, 8'hA5);
    rd_reg(ADR_CMP_B, v);
    chk("cmp b", v, 8'hA5);
  endtask

  // Compare A of 2 and B of 4 give gaps of 3 and 5, then flags clear on read
  task automatic t_alternate();
    int n;
    logic [7:0] v;
    setup(M_COUNT, 8'h0F, 8'h02, 8'h04, 8'h03, 8'h03);
    wr_reg(ADR_CTRL, 8'h01);
    wait_irq(600, n);
    chk("first irq", {7'h0, n < 600}, 8'h01);
    wait_irq(20, n);
    chk("gap b", n[7:0], 8'h05);
    wait_irq(20, n);
    chk("gap a", n[7:0], 8'h03);
    wr_reg(ADR_CTRL, 8'h00);
    rd_reg(ADR_STATUS, v);
    chk("flags", v, 8'h03);
    rd_reg(ADR_STATUS, v);
    chk("flags cleared", v, 8'h00);
  endtask

  // Single action on A: after one A match only B counts
  task automatic t_single();
    int n;
    logic [7:0] v;
    setup(M_COUNT, 8'h0F, 8'h02, 8'h04, 8'h0B, 8'h03);
    wr_reg(ADR_CTRL, 8'h01);
    wait_irq(600, n);
    repeat (3)
    begin
      wait_irq(20, n);
      chk("single gap", n[7:0], 8'h05);
    end
    wr_reg(ADR_CTRL, 8'h00);
    rd_reg(ADR_STATUS, v);
  endtask

  // Two live reads 300 cycles apart differ by 300 mod 256
  task automatic t_wrap();
    logic [7:0] a, b;
    setup(M_COUNT, 8'h0F, 8'hFF, 8'hFF, 8'h00, 8'h00);
    wr_reg(ADR_CTRL, 8'h01);
    // Let the live copy leave its start value before the first read
    repeat (4) @(posedge clk);
    rd_reg(ADR_CAPTURE, a);
    repeat (298) @(posedge clk);
    rd_reg(ADR_CAPTURE, b);
    chk("wrap", b - a, 8'h2C);
    wr_reg(ADR_CTRL, 8'h00);
    // Copy lags the cleared counter by one cycle
    @(posedge clk);
    rd_reg(ADR_CAPTURE, a);
    chk("stopped", a, 8'h00);
    wr_reg(ADR_CTRL, 8'h04);
    repeat (2) @(posedge clk);
    #1;
    chk("preset", {7'h0, own_tog}, 8'h01);
    wr_reg(ADR_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk("preset low", {7'h0, own_tog}, 8'h00);
  endtask

  // Serial bit picks half periods of 2 or 4 clocks
  task automatic t_fsk();
    int n;
    setup(M_FSK, 8'h0F, 8'h01, 8'h03, 8'h05, 8'h05);
    wr_reg(ADR_CTRL, 8'h01);
    wait_tog(600, n);
    wait_tog(20, n);
    chk("fsk low", n[7:0], 8'h02);
    i_peer.set_lines(1'b0, 1'b0, 1'b1);
    repeat (2) wait_tog(20, n);
    wait_tog(20, n);
    chk("fsk high", n[7:0], 8'h04);
    wr_reg(ADR_MODE, {4'h0, M_BURST_SER});
    i_peer.set_lines(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    n = 0;
    repeat (16) @(posedge clk) n += (tout !== 1'b0);
    chk("gated off", n[7:0], 8'h00);
    i_peer.set_lines(1'b0, 1'b0, 1'b1);
    repeat (3) @(posedge clk);
    n = 0;
    repeat (16) @(posedge clk) n += (tout === 1'b1);
    chk("gated on", {7'h0, n != 0}, 8'h01);
    wr_reg(ADR_CTRL, 8'h00);
  endtask

  // Edge interrupt only while stopped and for the chosen edge
  task automatic t_edge();
    int n;
    logic [7:0] v;
    setup(M_COUNT, 8'h0B, 8'hFF, 8'hFF, 8'h00, 8'h00);
    wr_reg(ADR_CTRL, 8'h08);
    rd_reg(ADR_STATUS, v);
    @(posedge clk) tin <= 1'b1;
    wait_irq(10, n);
    chk("edge irq", {7'h0, n < 8}, 8'h01);
    rd_reg(ADR_STATUS, v);
    chk("edge flag", v, 8'h04);
    @(posedge clk) tin <= 1'b0;
    wait_irq(10, n);
    chk("neg ignored", {7'h0, n < 10}, 8'h00);
    wr_reg(ADR_CTRL, 8'h09);
    @(posedge clk) tin <= 1'b1;
    wait_irq(10, n);
    chk("running", {7'h0, n < 10}, 8'h00);
    wr_reg(ADR_CTRL, 8'h00);
  endtask

  // Peer output appears on the pin
  task automatic t_route();
    wr_reg(ADR_MODE, {4'h0, M_COUNT_PEER});
    i_peer.set_lines(1'b0, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk("route high", {7'h0, tout}, 8'h01);
    i_peer.set_lines(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk("route low", {7'h0, tout}, 8'h00);
  endtask

  // Manchester: input level at each A match goes out on the shift pins
  task automatic t_manch();
    int n;
    setup(M_MANCH, 8'h03, 8'h04, 8'hFF, 8'h00, 8'h00);
    @(posedge clk) tin <= 1'b1;
    wr_reg(ADR_CTRL, 8'h01);
    n = 0;
    while (sclk !== 1'b1 && n < 20) @(posedge clk) n++;
    chk("shift one", {6'h0, sclk, sdata}, 8'h03);
    @(posedge clk) tin <= 1'b0;
    n = 0;
    while (sclk !== 1'b1 && n < 20) @(posedge clk) n++;
    chk("shift zero", {6'h0, sclk, sdata}, 8'h02);
    wr_reg(ADR_CTRL, 8'h00);
  endtask

  // Falling input edge copies the count and leaves the counter running
  task automatic t_capture();
    logic [7:0] v;
    setup(M_CAPTURE, 8'h07, 8'hFF, 8'hFF, 8'h00, 8'h00);
    wr_reg(ADR_CTRL, 8'h01);
    @(posedge clk) tin <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(ADR_CAPTURE, v);
    chk("capture", v, 8'h02);
    repeat (10) @(posedge clk);
    rd_reg(ADR_CAPTURE, v);
    chk("capture held", v, 8'h02);
    wr_reg(ADR_CTRL, 8'h00);
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_alternate();
    t_single();
    t_wrap();
    t_fsk();
    t_manch();
    t_edge();
    t_capture();
    t_route();
    test_done();
  end
endmodule
